/* File: logic/cog_event_shutdown.sv */
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`include "cog_evt_defines.svh"

module cog_event_shutdown
   import cog_evt_pkg::*;
(
   input  wire logic       I_CLK,
   input  wire logic       I_ARST_N,
   input  wire logic       I_CE,
   // event and shutdown sources
   input  wire logic       I_NUMERIC_OSC_OUTPUT,
   input  wire logic       I_THIRD_PULSE_WIDTH_OUTPUT,
   input  wire logic       I_CAPTURE_UNIT2_OUTPUT,
   input  wire logic       I_CAPTURE_UNIT1_OUTPUT,
   input  wire logic       I_LOGIC_CELL1_OUTPUT,
   input  wire logic       I_COMPARATOR2_OUTPUT,
   input  wire logic       I_COMPARATOR1_OUTPUT,
   input  wire logic       I_SELECTED_PIN,
   input  wire logic       I_LOGIC_CELL2_OUTPUT,
   // waveforms from the dead-band and steering stage
   input  wire logic       I_WAVE_A,
   input  wire logic       I_WAVE_B,
   input  wire logic       I_WAVE_C,
   input  wire logic       I_WAVE_D,
   // generator outputs
   output logic            O_OUTPUT_A,
   output logic            O_OUTPUT_A_OE,
   output logic            O_OUTPUT_B,
   output logic            O_OUTPUT_B_OE,
   output logic            O_OUTPUT_C,
   output logic            O_OUTPUT_C_OE,
   output logic            O_OUTPUT_D,
   output logic            O_OUTPUT_D_OE,
   output logic            O_RISE_EVENT,
   output logic            O_FALL_EVENT,
   output logic            O_SHUTDOWN_ACTIVE,
   // axi4-lite slave
   input  wire logic [7:0] I_S_AXI_AWADDR,
   input  wire logic       I_S_AXI_AWVALID,
   output logic            O_S_AXI_AWREADY,
   input  wire logic [31:0] I_S_AXI_WDATA,
   input  wire logic [3:0] I_S_AXI_WSTRB,
   input  wire logic       I_S_AXI_WVALID,
   output logic            O_S_AXI_WREADY,
   output logic [1:0]      O_S_AXI_BRESP,
   output logic            O_S_AXI_BVALID,
   input  wire logic       I_S_AXI_BREADY,
   input  wire logic [7:0] I_S_AXI_ARADDR,
   input  wire logic       I_S_AXI_ARVALID,
   output logic            O_S_AXI_ARREADY,
   output logic [31:0]     O_S_AXI_RDATA,
   output logic [1:0]      O_S_AXI_RRESP,
   output logic            O_S_AXI_RVALID,
   input  wire logic       I_S_AXI_RREADY
);

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic logic is_mapped(input logic [7:0] addr);
      is_mapped = (addr[1:0] == 2'b00) && (addr <= `OFS_INPUT_STATUS);
   endfunction

   // returns {output enable, level} for one pin
   function automatic logic [1:0] pin_drive(input logic [1:0] lvl, input logic pol,
                                            input logic wave, input logic sd);
      pin_drive = {1'b1, wave ^ pol};
      if (sd) begin
         case (lvl)
            `OVR_HIGH:  pin_drive = 2'b11;
            `OVR_LOW:   pin_drive = 2'b10;
            `OVR_FLOAT: pin_drive = 2'b00;
            default:    pin_drive = {1'b1, pol};
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------
   logic [7:0] rise_source_enable_q;
   logic [7:0] rise_mode_bit_q;
   logic [7:0] fall_source_enable_q;
   logic [7:0] fall_mode_bit_q;
   logic       auto_restart_enable_q;
   logic [1:0] pair_bd_override_level_q;
   logic [1:0] pair_ac_override_level_q;
   logic [3:0] shutdown_source_enables_q;
   logic [5:0] rise_phase_delay_q;
   logic [5:0] fall_phase_delay_q;
   logic [3:0] polarity_q;
   sd_state_t  sd_state_q;

   // ------------------------------------------------------------
   // axi4-lite write channel
   // ------------------------------------------------------------
   logic        aw_have_q;
   logic        w_have_q;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        bvalid_q;
   axi_resp_t   bresp_q;
   logic        do_write;
   logic        wr_en;

   assign O_S_AXI_AWREADY = I_CE && !aw_have_q && !bvalid_q; // low while frozen, no lost beat
   assign O_S_AXI_WREADY = I_CE && !w_have_q && !bvalid_q;
   assign O_S_AXI_BVALID = bvalid_q;
   assign O_S_AXI_BRESP = bresp_q;
   assign do_write = aw_have_q && w_have_q && !bvalid_q;
   // registers are at most eight bits wide, so only the low byte lane matters
   assign wr_en = do_write && w_strb_q[0] && is_mapped(aw_addr_q);

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end else if (I_CE) begin
         if (I_S_AXI_AWVALID && O_S_AXI_AWREADY) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= I_S_AXI_AWADDR;
         end
         if (I_S_AXI_WVALID && O_S_AXI_WREADY) begin
            w_have_q <= 1'b1;
            w_data_q <= I_S_AXI_WDATA;
            w_strb_q <= I_S_AXI_WSTRB;
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid_q && I_S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // axi4-lite read channel
   // ------------------------------------------------------------
   logic [31:0] rdata_q;
   logic        rvalid_q;
   axi_resp_t   rresp_q;
   logic [7:0]  rd_byte;
   logic [7:0]  src_vec;
   logic [7:0]  sd_ctl_view;

   assign O_S_AXI_ARREADY = I_CE && !rvalid_q;
   assign O_S_AXI_RVALID = rvalid_q;
   assign O_S_AXI_RDATA = rdata_q;
   assign O_S_AXI_RRESP = rresp_q;

   // status reads 1 only in the shut state, armed reads 0
   assign sd_ctl_view = {sd_state_q == SD_SHUT, auto_restart_enable_q,
                         pair_bd_override_level_q, pair_ac_override_level_q,
                         2'b00};

   always_comb begin
      case (I_S_AXI_ARADDR)
         `OFS_RISE_SRC_EN:  rd_byte = rise_source_enable_q;
         `OFS_RISE_MODE:    rd_byte = rise_mode_bit_q;
         `OFS_FALL_SRC_EN:  rd_byte = fall_source_enable_q;
         `OFS_FALL_MODE:    rd_byte = fall_mode_bit_q;
         `OFS_SHUTDOWN_CTL: rd_byte = sd_ctl_view;
         `OFS_SHUTDOWN_SRC: rd_byte = {4'h0, shutdown_source_enables_q};
         `OFS_RISE_PHASE:   rd_byte = {2'b00, rise_phase_delay_q};
         `OFS_FALL_PHASE:   rd_byte = {2'b00, fall_phase_delay_q};
         `OFS_POLARITY:     rd_byte = {4'h0, polarity_q};
         `OFS_INPUT_STATUS: rd_byte = src_vec;
         default:           rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rdata_q <= 32'h0000_0000;
         rvalid_q <= 1'b0;
         rresp_q <= `RESP_OKAY;
      end else if (I_CE) begin
         if (I_S_AXI_ARVALID && O_S_AXI_ARREADY) begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_byte};
            rresp_q <= is_mapped(I_S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rvalid_q && I_S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rise_source_enable_q <= `RST_REG8;
         rise_mode_bit_q <= `RST_REG8;
         fall_source_enable_q <= `RST_REG8;
         fall_mode_bit_q <= `RST_REG8;
         auto_restart_enable_q <= 1'b0;
         pair_bd_override_level_q <= `OVR_INACTIVE;
         pair_ac_override_level_q <= `OVR_INACTIVE;
         shutdown_source_enables_q <= `RST_NIBBLE;
         rise_phase_delay_q <= `RST_PHASE;
         fall_phase_delay_q <= `RST_PHASE;
         polarity_q <= `RST_NIBBLE;
      end else if (I_CE && wr_en) begin
         case (aw_addr_q)
            `OFS_RISE_SRC_EN: rise_source_enable_q <= w_data_q[7:0];
            `OFS_RISE_MODE:   rise_mode_bit_q <= w_data_q[7:0];
            `OFS_FALL_SRC_EN: fall_source_enable_q <= w_data_q[7:0];
            `OFS_FALL_MODE:   fall_mode_bit_q <= w_data_q[7:0];
            `OFS_SHUTDOWN_CTL: begin
               auto_restart_enable_q <= w_data_q[`SDC_RESTART_BIT];
               pair_bd_override_level_q <= w_data_q[`SDC_BD_HI:`SDC_BD_LO];
               pair_ac_override_level_q <= w_data_q[`SDC_AC_HI:`SDC_AC_LO];
            end
            `OFS_SHUTDOWN_SRC: shutdown_source_enables_q <= w_data_q[3:0];
            `OFS_RISE_PHASE:   rise_phase_delay_q <= w_data_q[5:0];
            `OFS_FALL_PHASE:   fall_phase_delay_q <= w_data_q[5:0];
            `OFS_POLARITY:     polarity_q <= w_data_q[3:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // event qualification
   // ------------------------------------------------------------
   // bit order matches the enable and mode registers
   assign src_vec = {I_NUMERIC_OSC_OUTPUT, I_THIRD_PULSE_WIDTH_OUTPUT,
                     I_CAPTURE_UNIT2_OUTPUT, I_CAPTURE_UNIT1_OUTPUT,
                     I_LOGIC_CELL1_OUTPUT, I_COMPARATOR2_OUTPUT,
                     I_COMPARATOR1_OUTPUT, I_SELECTED_PIN};

   logic [7:0] src_q;
   logic [7:0] dir_en [2];
   logic [7:0] dir_mode [2];
   logic [5:0] dir_delay [2];
   logic [1:0] evt_q;

   assign dir_en[0] = rise_source_enable_q;
   assign dir_en[1] = fall_source_enable_q;
   assign dir_mode[0] = rise_mode_bit_q;
   assign dir_mode[1] = fall_mode_bit_q;
   assign dir_delay[0] = rise_phase_delay_q;
   assign dir_delay[1] = fall_phase_delay_q;

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         src_q <= 8'h00;
      end else if (I_CE) begin
         src_q <= src_vec;
      end
   end

   // direction 0 is rising, direction 1 is falling (sources inverted)
   for (genvar d = 0; d < 2; d++) begin : g_dir
      logic [7:0] act;
      logic [7:0] act_prev;
      logic       level_hit;
      logic       edge_hit;
      logic       fire;
      logic       busy_q;
      logic [5:0] cnt_q;

      assign act = (d == 0) ? src_vec : ~src_vec;
      assign act_prev = (d == 0) ? src_q : ~src_q;
      // level mode acts at once, enable gates both modes
      assign level_hit = |(dir_en[d] & ~dir_mode[d] & act);
      // edge mode: a new transition on any enabled source
      assign edge_hit = |(dir_en[d] & dir_mode[d] & act & ~act_prev);
      assign fire = (busy_q && cnt_q == 6'h01) ||
                    (!busy_q && edge_hit && dir_delay[d] == 6'h00);

      // an edge seen while a delay is running is absorbed by that delay
      always_ff @(posedge I_CLK or negedge I_ARST_N) begin
         if (!I_ARST_N) begin
            busy_q <= 1'b0;
            cnt_q <= `RST_PHASE;
         end else if (I_CE) begin
            if (busy_q) begin
               cnt_q <= cnt_q - 6'h01;
               if (cnt_q == 6'h01) begin
                  busy_q <= 1'b0;
               end
            end else if (edge_hit && dir_delay[d] != 6'h00) begin
               busy_q <= 1'b1;
               cnt_q <= dir_delay[d];
            end
         end
      end

      always_ff @(posedge I_CLK or negedge I_ARST_N) begin
         if (!I_ARST_N) begin
            evt_q[d] <= 1'b0;
         end else if (I_CE) begin
            evt_q[d] <= level_hit || fire;
         end
      end
   end

   assign O_RISE_EVENT = evt_q[0];
   assign O_FALL_EVENT = evt_q[1];

   // ------------------------------------------------------------
   // shutdown controller
   // ------------------------------------------------------------
   logic sd_hit;
   logic sd_status_wr;

   // a low level on any enabled source forces shutdown
   assign sd_hit = |(shutdown_source_enables_q &
                     ~{I_LOGIC_CELL2_OUTPUT, I_COMPARATOR2_OUTPUT,
                       I_COMPARATOR1_OUTPUT, I_SELECTED_PIN});
   assign sd_status_wr = wr_en && aw_addr_q == `OFS_SHUTDOWN_CTL;

   // reset lands in armed: status reads 0 but outputs stay overridden
   // until the first rising event, so start-up is always synchronous
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         sd_state_q <= SD_ARMED;
      end else if (I_CE) begin
         if (sd_hit) begin
            sd_state_q <= SD_SHUT; // hardware set beats software clear
         end else begin
            case (sd_state_q)
               SD_RUN: begin
                  if (sd_status_wr && w_data_q[`SDC_STATUS_BIT]) begin
                     sd_state_q <= SD_SHUT;
                  end
               end
               SD_SHUT: begin
                  if (sd_status_wr && !w_data_q[`SDC_STATUS_BIT]) begin
                     sd_state_q <= SD_ARMED;
                  end else if (auto_restart_enable_q &&
                               !(sd_status_wr && w_data_q[`SDC_STATUS_BIT])) begin
                     sd_state_q <= SD_ARMED;
                  end
               end
               SD_ARMED: begin
                  if (sd_status_wr && w_data_q[`SDC_STATUS_BIT]) begin
                     sd_state_q <= SD_SHUT;
                  end else if (evt_q[0]) begin
                     sd_state_q <= SD_RUN;
                  end
               end
               default: sd_state_q <= SD_SHUT;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // output override
   // ------------------------------------------------------------
   logic [3:0] out_q;
   logic [3:0] oe_q;
   logic [3:0] wave;
   logic       sd_active;

   assign wave = {I_WAVE_D, I_WAVE_C, I_WAVE_B, I_WAVE_A};
   assign sd_active = sd_state_q != SD_RUN;

   // bits 0 and 2 are the a/c pair, bits 1 and 3 the b/d pair
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         out_q <= 4'h0;
         oe_q <= 4'h0;
      end else if (I_CE) begin
         for (int i = 0; i < 4; i++) begin
            {oe_q[i], out_q[i]} <= pin_drive(i[0] ? pair_bd_override_level_q
                                                  : pair_ac_override_level_q,
                                             polarity_q[i], wave[i],
                                             sd_active);
         end
      end
   end

   assign O_OUTPUT_A = out_q[0];
   assign O_OUTPUT_B = out_q[1];
   assign O_OUTPUT_C = out_q[2];
   assign O_OUTPUT_D = out_q[3];
   assign O_OUTPUT_A_OE = oe_q[0];
   assign O_OUTPUT_B_OE = oe_q[1];
   assign O_OUTPUT_C_OE = oe_q[2];
   assign O_OUTPUT_D_OE = oe_q[3];
   assign O_SHUTDOWN_ACTIVE = sd_active;

endmodule

/* File: common/cog_evt_defines.svh */
`ifndef COG_EVT_DEFINES_SVH
`define COG_EVT_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_RISE_SRC_EN   8'h00
`define OFS_RISE_MODE     8'h04
`define OFS_FALL_SRC_EN   8'h08
`define OFS_FALL_MODE     8'h0c
`define OFS_SHUTDOWN_CTL  8'h10
`define OFS_SHUTDOWN_SRC  8'h14
`define OFS_RISE_PHASE    8'h18
`define OFS_FALL_PHASE    8'h1c
`define OFS_POLARITY      8'h20
`define OFS_INPUT_STATUS  8'h24

// ------------------------------------------------------------
// shutdown_control field positions
// ------------------------------------------------------------
`define SDC_STATUS_BIT    7
`define SDC_RESTART_BIT   6
`define SDC_BD_HI         5
`define SDC_BD_LO         4
`define SDC_AC_HI         3
`define SDC_AC_LO         2

// ------------------------------------------------------------
// override level encodings
// ------------------------------------------------------------
`define OVR_HIGH          2'b11
`define OVR_LOW           2'b10
`define OVR_FLOAT         2'b01
`define OVR_INACTIVE      2'b00

// ------------------------------------------------------------
// reset values and widths
// ------------------------------------------------------------
`define RST_REG8          8'h00
`define RST_PHASE         6'h00
`define RST_NIBBLE        4'h0
`define PHASE_W           6
`define ADDR_W            8

// ------------------------------------------------------------
// bus responses
// ------------------------------------------------------------
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

/* File: common/cog_evt_pkg.sv */
package cog_evt_pkg;
   // shutdown controller states, one-hot
   typedef enum logic [2:0] {
      SD_RUN   = 3'b001,
      SD_SHUT  = 3'b010,
      SD_ARMED = 3'b100
   } sd_state_t;

   typedef logic [1:0] axi_resp_t;
endpackage

/* File: testbench/cog_event_shutdown_props.sv */
module cog_event_shutdown_props (
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   input wire logic I_CE,
   input wire logic I_S_AXI_AWVALID,
   input wire logic O_S_AXI_AWREADY,
   input wire logic I_S_AXI_WVALID,
   input wire logic O_S_AXI_WREADY,
   input wire logic [1:0] O_S_AXI_BRESP,
   input wire logic O_S_AXI_BVALID,
   input wire logic I_S_AXI_BREADY,
   input wire logic I_S_AXI_ARVALID,
   input wire logic O_S_AXI_ARREADY,
   input wire logic [31:0] O_S_AXI_RDATA,
   input wire logic O_S_AXI_RVALID,
   input wire logic I_S_AXI_RREADY,
   input wire logic O_OUTPUT_A,
   input wire logic O_OUTPUT_A_OE,
   input wire logic O_OUTPUT_B,
   input wire logic O_OUTPUT_B_OE,
   input wire logic O_OUTPUT_C,
   input wire logic O_OUTPUT_C_OE,
   input wire logic O_OUTPUT_D,
   input wire logic O_OUTPUT_D_OE,
   input wire logic O_RISE_EVENT,
   input wire logic O_SHUTDOWN_ACTIVE
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_ARST_N);
   // ------------------------------------------------------------
   // register bus
   // ------------------------------------------------------------
   sequence wr_taken;
      I_CE && I_S_AXI_AWVALID && O_S_AXI_AWREADY && I_S_AXI_WVALID && O_S_AXI_WREADY;
   endsequence
   sequence resp_up;
      ##2 O_S_AXI_BVALID;
   endsequence
   a_write_resp: assert property (wr_taken |-> resp_up)
      else $error("write response late");
   a_bresp_hold: assert property (O_S_AXI_BVALID && !I_S_AXI_BREADY |=> O_S_AXI_BVALID && $stable(O_S_AXI_BRESP))
      else $error("write response dropped");
   a_read_resp: assert property (I_CE && I_S_AXI_ARVALID && O_S_AXI_ARREADY |=> O_S_AXI_RVALID)
      else $error("read response late");
   a_rdata_hold: assert property (O_S_AXI_RVALID && !I_S_AXI_RREADY |=> O_S_AXI_RVALID && $stable(O_S_AXI_RDATA))
      else $error("read data dropped");
   a_no_ar_busy: assert property (O_S_AXI_RVALID |-> !O_S_AXI_ARREADY)
      else $error("read accepted while busy");
   a_upper_zero: assert property (O_S_AXI_RVALID |-> O_S_AXI_RDATA[31:8] == 24'h0)
      else $error("upper read bits set");
   // ------------------------------------------------------------
   // outputs and shutdown
   // ------------------------------------------------------------
   a_float_zero: assert property (({O_OUTPUT_D, O_OUTPUT_C, O_OUTPUT_B, O_OUTPUT_A} & ~{O_OUTPUT_D_OE, O_OUTPUT_C_OE, O_OUTPUT_B_OE, O_OUTPUT_A_OE}) == 4'h0)
      else $error("floating output not zero");
   a_pair_oe: assert property (O_OUTPUT_A_OE == O_OUTPUT_C_OE && O_OUTPUT_B_OE == O_OUTPUT_D_OE)
      else $error("pair enables differ");
   a_float_shut: assert property (!(O_OUTPUT_A_OE && O_OUTPUT_B_OE) |-> $past(O_SHUTDOWN_ACTIVE))
      else $error("float outside shutdown");
   a_leave_armed: assert property ($fell(O_SHUTDOWN_ACTIVE) |-> $past(O_RISE_EVENT))
      else $error("left shutdown without rising event");
endmodule

/* File: testbench/event_source_model.sv */
module event_source_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [8:0] i_want,
   input wire logic [3:0] i_lag,
   output logic [8:0] o_src
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_q;
   // sources idle high so that no shutdown source fires before it is asked to;
   // a change lands i_lag cycles late to mimic a slow peripheral
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_src <= 9'h1ff;
         wait_q <= 4'h0;
      end else if (i_want == o_src) begin
         wait_q <= 4'h0;
      end else if (wait_q >= i_lag) begin
         o_src <= i_want;
         wait_q <= 4'h0;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule

/* File: testbench/complementary_output_event_shutdown_test.sv */
module complementary_output_event_shutdown_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, arst_n, awv, wv, bready, arv, rready, aw_rdy, w_rdy, bvalid, ar_rdy, rvalid;
   logic rise_ev, fall_ev, sd, ce;
   logic [3:0] wave, wprev, pol, lag;
   logic [8:0] want, src;
   logic [7:0] awaddr, araddr, oab;
   logic [31:0] wdata, rdata, v;
   logic [1:0] bresp, rresp;
   logic [5:0] ph;
   int n_mismatch = 0, n_tests = 0, seed = 7, l0, l1, n;
   cog_event_shutdown uut (.I_CLK(clk), .I_ARST_N(arst_n), .I_CE(ce),
      .I_NUMERIC_OSC_OUTPUT(src[7]), .I_THIRD_PULSE_WIDTH_OUTPUT(src[6]),
      .I_CAPTURE_UNIT2_OUTPUT(src[5]), .I_CAPTURE_UNIT1_OUTPUT(src[4]),
      .I_LOGIC_CELL1_OUTPUT(src[3]), .I_COMPARATOR2_OUTPUT(src[2]),
      .I_COMPARATOR1_OUTPUT(src[1]), .I_SELECTED_PIN(src[0]), .I_LOGIC_CELL2_OUTPUT(src[8]),
      .I_WAVE_A(wave[0]), .I_WAVE_B(wave[1]), .I_WAVE_C(wave[2]), .I_WAVE_D(wave[3]),
      .O_OUTPUT_A(oab[0]), .O_OUTPUT_A_OE(oab[1]), .O_OUTPUT_B(oab[2]), .O_OUTPUT_B_OE(oab[3]),
      .O_OUTPUT_C(oab[4]), .O_OUTPUT_C_OE(oab[5]), .O_OUTPUT_D(oab[6]), .O_OUTPUT_D_OE(oab[7]),
      .O_RISE_EVENT(rise_ev), .O_FALL_EVENT(fall_ev), .O_SHUTDOWN_ACTIVE(sd),
      .I_S_AXI_AWADDR(awaddr), .I_S_AXI_AWVALID(awv), .O_S_AXI_AWREADY(aw_rdy),
      .I_S_AXI_WDATA(wdata), .I_S_AXI_WSTRB(4'hf), .I_S_AXI_WVALID(wv), .O_S_AXI_WREADY(w_rdy),
      .O_S_AXI_BRESP(bresp), .O_S_AXI_BVALID(bvalid), .I_S_AXI_BREADY(bready),
      .I_S_AXI_ARADDR(araddr), .I_S_AXI_ARVALID(arv), .O_S_AXI_ARREADY(ar_rdy),
      .O_S_AXI_RDATA(rdata), .O_S_AXI_RRESP(rresp), .O_S_AXI_RVALID(rvalid),
      .I_S_AXI_RREADY(rready));
   event_source_model src_m (.i_clk(clk), .i_rst_n(arst_n), .i_want(want), .i_lag(lag),
      .o_src(src));
   // ------------------------------------------------------------
   // clock, waveforms, watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      wave <= 4'($random(seed));
      wprev <= wave;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      end_sim;
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task end_sim;
      if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (aw_rdy) awv <= 1'b0;
         if (w_rdy) wv <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", er, bresp);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (ar_rdy) arv <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("rdata", exp, rdata);
      chk("rresp", er, rresp);
   endtask
   function automatic logic [1:0] ovr(input logic [1:0] c, input logic p);
      case (c)
         2'b11: return 2'b11;
         2'b10: return 2'b10;
         2'b01: return 2'b00;
         default: return {1'b1, p};
      endcase
   endfunction
   // other sources stay enabled at their idle level with the opposite mode bit, so a
   // swapped bit position or a missing OR shows up as a wrong latency
   task evt(input int d, input int i, input logic m, input logic e, input logic [5:0] p,
            output int lat);
      logic lvl;
      lvl = (d == 0);
      lag <= 4'($random(seed) & 3);
      wr(8'h18 + 8'(4 * d), {26'h0, p}, 2'b00);
      wr(8'h04 + 8'(8 * d), m ? 32'h1 << i : ~(32'h1 << i), 2'b00);
      wr(8'h00 + 8'(8 * d), e ? 32'hff : ~(32'h1 << i), 2'b00);
      repeat (3) @(posedge clk);
      want[i] <= lvl;
      do begin
         @(posedge clk);
         #1;
      end while (src[i] !== lvl);
      lat = 0;
      while ((d ? fall_ev : rise_ev) !== 1'b1 && lat < 12) begin
         @(posedge clk);
         #1;
         lat++;
      end
      @(posedge clk);
      #1;
      if (e) chk("hold", {31'h0, !m}, {31'h0, d ? fall_ev : rise_ev});
      want[i] <= !lvl;
      wr(8'h00 + 8'(8 * d), 32'h0, 2'b00);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      {want, lag} = 13'h1ff0;
      {wave, wprev} = 8'h00;
      {awaddr, araddr, wdata} = '0;
      {awv, wv, bready, arv, rready, ce} = 6'h01;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      #1 chk("sd", 1, sd);
      for (int a = 0; a < 5; a++) rd(8'(4 * a), 32'h0, 2'b00);
      for (int k = 0; k < 8; k++) begin
         v = $random(seed);
         wr(8'(4 * (k % 4)), v, 2'b00);
         rd(8'(4 * (k % 4)), {24'h0, v[7:0]}, 2'b00);
         wr(8'(4 * (k % 4)), 32'h0, 2'b00);
      end
      wr(8'h10, v & 32'hffffff3f, 2'b00);
      rd(8'h10, v & 32'h3c, 2'b00);
      wr(8'h30, v, 2'b10);
      rd(8'h30, 32'h0, 2'b10);
      rd(8'h02, 32'h0, 2'b10);
      for (int d = 0; d < 2; d++) begin
         want <= d ? 9'h1ff : 9'h100;
         for (int i = 0; i < 8; i++) begin
            evt(d, i, 1'b0, 1'b1, 6'h0, n);
            chk("level", 1, n);
            evt(d, i, 1'b1, 1'b1, 6'h0, l0);
            ph = 6'(1 + {$random(seed)} % 7);
            evt(d, i, 1'b1, 1'b1, ph, l1);
            chk("phase", {26'h0, ph}, l1 - l0);
            evt(d, i, 1'($random(seed)), 1'b0, ph, n);
            chk("off", 12, n);
         end
      end
      want <= 9'h1ff;
      lag <= 4'h0;
      pol = 4'($random(seed));
      wr(8'h20, {28'h0, pol}, 2'b00);
      wr(8'h04, 32'h0, 2'b00);
      wr(8'h00, 32'h02, 2'b00);
      wr(8'h14, 32'h02, 2'b00);
      want[1] <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk("sd", 1, sd);
      for (int c = 0; c < 16; c++) begin
         wr(8'h10, 32'h83 | (c << 2), 2'b00);
         repeat (2) @(posedge clk);
         #1 chk("ovr", {ovr(2'(c >> 2), pol[3]), ovr(2'(c), pol[2]), ovr(2'(c >> 2), pol[1]), ovr(2'(c), pol[0])}, oab);
         rd(8'h10, 32'h80 | (c << 2), 2'b00);
      end
      want[1] <= 1'b1;
      wr(8'h10, 32'h0, 2'b00);
      repeat (4) @(posedge clk);
      #1 chk("sd", 0, sd);
      for (int k = 0; k < 4; k++) chk("run", {1'b1, wprev[k] ^ pol[k]}, oab[2*k +: 2]);
      @(posedge clk);
      ce <= 1'b0;
      want[1] <= 1'b0;
      repeat (4) @(posedge clk);
      want[1] <= 1'b1;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      #1 chk("frozen", 0, sd);
      for (int s = 0; s < 4; s++) begin
         wr(8'h14, 32'h1 << s, 2'b00);
         wr(8'h10, 32'h40, 2'b00);
         want[s == 3 ? 8 : s] <= 1'b0;
         repeat (4) @(posedge clk);
         #1 chk("sd", 1, sd);
         rd(8'h10, 32'hc0, 2'b00);
         want[s == 3 ? 8 : s] <= 1'b1;
         repeat (6) @(posedge clk);
         #1 chk("sd", 0, sd);
      end
      end_sim;
   end
endmodule

bind cog_event_shutdown cog_event_shutdown_props chk_i (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
   .I_CE(I_CE), .I_S_AXI_AWVALID(I_S_AXI_AWVALID), .O_S_AXI_AWREADY(O_S_AXI_AWREADY),
   .I_S_AXI_WVALID(I_S_AXI_WVALID), .O_S_AXI_WREADY(O_S_AXI_WREADY),
   .O_S_AXI_BRESP(O_S_AXI_BRESP), .O_S_AXI_BVALID(O_S_AXI_BVALID),
   .I_S_AXI_BREADY(I_S_AXI_BREADY), .I_S_AXI_ARVALID(I_S_AXI_ARVALID),
   .O_S_AXI_ARREADY(O_S_AXI_ARREADY), .O_S_AXI_RDATA(O_S_AXI_RDATA),
   .O_S_AXI_RVALID(O_S_AXI_RVALID), .I_S_AXI_RREADY(I_S_AXI_RREADY),
   .O_OUTPUT_A(O_OUTPUT_A), .O_OUTPUT_A_OE(O_OUTPUT_A_OE), .O_OUTPUT_B(O_OUTPUT_B),
   .O_OUTPUT_B_OE(O_OUTPUT_B_OE), .O_OUTPUT_C(O_OUTPUT_C), .O_OUTPUT_C_OE(O_OUTPUT_C_OE),
   .O_OUTPUT_D(O_OUTPUT_D), .O_OUTPUT_D_OE(O_OUTPUT_D_OE), .O_RISE_EVENT(O_RISE_EVENT),
   .O_SHUTDOWN_ACTIVE(O_SHUTDOWN_ACTIVE));
